// >>> hdl/sps_pkg.sv
package sps_pkg;

    // integer width variants
    typedef enum logic [1:0] {
        SPS_EMB32,
        SPS_RV32,
        SPS_RV64
    } sps_variant_t;

    // trap causes reported to the core
    typedef enum logic [1:0] {
        SPS_CAUSE_NONE,
        SPS_CAUSE_ILLEGAL,
        SPS_CAUSE_ACCESS,
        SPS_CAUSE_INTR
    } sps_cause_t;

    localparam int          SPS_ADDR_W      = 64;
    localparam int          SPS_SLOTS       = 13;
    localparam logic [3:0]  SPS_LAST_IDX    = 4'hc;
    localparam logic [3:0]  SPS_SLOT_X27    = 4'h0;
    localparam logic [3:0]  SPS_SLOT_X26    = 4'h1;
    localparam logic [3:0]  SPS_RLIST_MIN   = 4'h4;
    localparam logic [3:0]  SPS_RLIST_FULL  = 4'hf;
    localparam logic [3:0]  SPS_RLIST_BIAS  = 4'h3;
    localparam logic [3:0]  SPS_FULL_COUNT  = 4'hd;
    localparam logic [3:0]  SPS_BYTES_W     = 4'h4;
    localparam logic [3:0]  SPS_BYTES_D     = 4'h8;
    localparam logic [7:0]  SPS_FRAME_UNIT  = 8'h10;

    // apb register map, byte addresses
    localparam logic [7:0]  SPS_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  SPS_ADDR_STATUS = 8'h04;
    localparam logic [7:0]  SPS_ADDR_ISTAT  = 8'h08;
    localparam logic [7:0]  SPS_ADDR_IMASK  = 8'h0c;
    localparam logic [7:0]  SPS_ADDR_COUNT  = 8'h10;
    localparam logic [1:0]  SPS_CTRL_RST    = 2'h1;

    // event bits of status and mask
    localparam int          SPS_EV_W        = 4;
    localparam int          SPS_EV_DONE     = 0;
    localparam int          SPS_EV_ILLEGAL  = 1;
    localparam int          SPS_EV_FAULT    = 2;
    localparam int          SPS_EV_ABORT    = 3;

    // register number for a slot, slot 0 is stored first
    function automatic logic [4:0] sps_reg_num(input logic [3:0] idx);
        logic [4:0] r;
        r = 5'h01;
        if (idx < 4'ha)
            r = 5'h1b - {1'b0, idx};
        else if (idx == 4'ha)
            r = 5'h09;
        else if (idx == 4'hb)
            r = 5'h08;
        return r;
    endfunction : sps_reg_num

endpackage : sps_pkg

// >>> hdl/sps_frame_decode.sv
`timescale 1ns/1ps
module sps_frame_decode
    import sps_pkg::*;
(
    // instruction fields
    input  wire logic [1:0]  variant_in,
    input  wire logic [3:0]  rlist_in,
    input  wire logic [5:0]  spimm_in,
    // decoded frame
    output logic             reserved_out,
    output logic             illegal_out,
    output logic [12:0]      sel_out,
    output logic [3:0]       first_idx_out,
    output logic [7:0]       base_out,
    output logic [7:0]       frame_adj_out,
    output logic [3:0]       reg_bytes_out
);
    logic [3:0] count;
    logic [7:0] base;
    logic [7:0] used;

    assign reserved_out  = rlist_in < SPS_RLIST_MIN;
    assign count         = (rlist_in == SPS_RLIST_FULL) ? SPS_FULL_COUNT : rlist_in - SPS_RLIST_BIAS;
    assign first_idx_out = SPS_FULL_COUNT - count;
    assign reg_bytes_out = (variant_in == SPS_RV64) ? SPS_BYTES_D : SPS_BYTES_W;
    assign used          = 8'(count) * 8'(reg_bytes_out);

    // selected slots form the tail of the descending order, so x26 never without x27
    genvar i;
    generate
        for (i = 0; i < SPS_SLOTS; i++)
        begin : g_sel
            assign sel_out[i] = !reserved_out && (4'(i) >= first_idx_out);
        end
    endgenerate

    always_comb
    begin
        base = SPS_FRAME_UNIT;
        unique case (variant_in)
            SPS_EMB32: base = SPS_FRAME_UNIT;
            SPS_RV32:
            begin
                if (rlist_in <= 4'h7)       base = 8'h10;
                else if (rlist_in <= 4'hb)  base = 8'h20;
                else if (rlist_in <= 4'he)  base = 8'h30;
                else                        base = 8'h40;
            end
            default:
            begin
                if (rlist_in <= 4'h5)       base = 8'h10;
                else if (rlist_in <= 4'h7)  base = 8'h20;
                else if (rlist_in <= 4'h9)  base = 8'h30;
                else if (rlist_in <= 4'hb)  base = 8'h40;
                else if (rlist_in <= 4'hd)  base = 8'h50;
                else if (rlist_in == 4'he)  base = 8'h60;
                else                        base = 8'h70;
            end
        endcase
    end

    assign base_out      = base;
    assign frame_adj_out = base + 8'(spimm_in[5:4]) * SPS_FRAME_UNIT;
    // the frame must cover the registers, and an undefined variant code is refused
    assign illegal_out   = reserved_out || (used > base) || (variant_in > SPS_RV64);

endmodule : sps_frame_decode

// >>> hdl/sps_sequencer.sv
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - register-list codes 0 to 3 are reserved and never executed
// - code 4 is x1, 5 adds x8, 6 x9, then x18 upward; 15 all
// - x26 is never selected without x27; software uses code 15
// - frame adjustment is base size plus spimm bits 5:4 times sixteen
// - embedded 32-bit base size is always sixteen bytes
// - 32-bit base size: 16, 32, 48, 64 by register-list code group
// - 64-bit base size: 16 up to 112 by register-list code group
// - word accesses of four bytes at width 32, doublewords otherwise
// - push starts at sp minus one register, x27 down to x1, descending
// - push stores everything first, then lowers sp by full frame
// - the access phase may be restarted from the beginning
// - sp is committed once, only after all accesses succeed uninterrupted
// - pop loads everything first, then raises sp by full frame
// - pop starts at sp plus frame minus one register, descending
// - on a trap report instruction pc, faulting address and cause
module sps_sequencer
    import sps_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_n_in,
    // apb slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [7:0]            paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic                       pready_out,
    output logic [31:0]                prdata_out,
    output logic                       pslverr_out,
    // instruction from the core
    input  wire logic                  start_in,
    input  wire logic                  is_push_in,
    input  wire logic [3:0]            rlist_in,
    input  wire logic [5:0]            spimm_in,
    input  wire logic [SPS_ADDR_W-1:0] sp_in,
    input  wire logic [SPS_ADDR_W-1:0] pc_in,
    input  wire logic                  intr_in,
    // load/store path
    output logic                       mem_req_out,
    output logic                       mem_write_out,
    output logic                       mem_dword_out,
    output logic [SPS_ADDR_W-1:0]      mem_addr_out,
    output logic [4:0]                 mem_reg_out,
    input  wire logic                  mem_ack_in,
    input  wire logic                  mem_err_in,
    // completion and traps
    output logic                       busy_out,
    output logic                       done_out,
    output logic                       sp_we_out,
    output logic [SPS_ADDR_W-1:0]      sp_new_out,
    output logic                       trap_out,
    output sps_cause_t                 trap_cause_out,
    output logic [SPS_ADDR_W-1:0]      trap_epc_out,
    output logic [SPS_ADDR_W-1:0]      trap_tval_out,
    // interrupt
    output logic                       irq_out
);
    typedef enum logic {ST_IDLE, ST_ACCESS} sps_state_t;

    sps_state_t            state_q, state_d;
    logic [1:0]            ctrl_q;
    logic [SPS_EV_W-1:0]   istat_q, imask_q, ev_set;
    logic [31:0]           count_q;
    logic [3:0]            idx_q, bytes_q;
    logic [7:0]            adj_q;
    logic                  push_q;
    logic [SPS_ADDR_W-1:0] sp_q, pc_q;

    logic                  dec_reserved, dec_illegal;
    logic [12:0]           dec_sel;
    logic [3:0]            dec_first, dec_bytes;
    logic [7:0]            dec_base, dec_adj;

    sps_frame_decode u_dec (
        .variant_in    (ctrl_q),
        .rlist_in      (rlist_in),
        .spimm_in      (spimm_in),
        .reserved_out  (dec_reserved),
        .illegal_out   (dec_illegal),
        .sel_out       (dec_sel),
        .first_idx_out (dec_first),
        .base_out      (dec_base),
        .frame_adj_out (dec_adj),
        .reg_bytes_out (dec_bytes)
    );

    // decode of events and apb access
    wire                  idle     = state_q == ST_IDLE;
    wire                  go       = idle && start_in;
    wire                  refuse   = go && dec_illegal;
    wire                  accept   = go && !dec_illegal;
    wire                  ack_ok   = !idle && mem_ack_in && !mem_err_in;
    wire                  fault    = !idle && mem_ack_in && mem_err_in;
    wire                  abort    = !idle && !mem_ack_in && intr_in;
    wire                  last     = idx_q == SPS_LAST_IDX;
    wire                  commit   = ack_ok && last;
    wire [SPS_ADDR_W-1:0] bytes_x  = SPS_ADDR_W'(dec_bytes);
    wire [SPS_ADDR_W-1:0] adj_x    = SPS_ADDR_W'(dec_adj);
    wire [SPS_ADDR_W-1:0] first_a  = is_push_in ? sp_in - bytes_x : sp_in + adj_x - bytes_x;
    wire [SPS_ADDR_W-1:0] step_a   = mem_addr_out - SPS_ADDR_W'(bytes_q);
    wire [SPS_ADDR_W-1:0] sp_fin   = push_q ? sp_q - SPS_ADDR_W'(adj_q) : sp_q + SPS_ADDR_W'(adj_q);
    wire                  apb_acc  = psel_in && penable_in && !pready_out;
    wire                  apb_wr   = apb_acc && pwrite_in;
    wire                  hit_ctrl = paddr_in == SPS_ADDR_CTRL;
    wire                  hit_stat = paddr_in == SPS_ADDR_STATUS;
    wire                  hit_ist  = paddr_in == SPS_ADDR_ISTAT;
    wire                  hit_imk  = paddr_in == SPS_ADDR_IMASK;
    wire                  hit_cnt  = paddr_in == SPS_ADDR_COUNT;
    wire                  hit_any  = hit_ctrl || hit_stat || hit_ist || hit_imk || hit_cnt;
    wire [31:0]           rd_mux   = hit_ctrl ? {30'h0, ctrl_q} :
                                     hit_stat ? {27'h0, idx_q, !idle} :
                                     hit_ist  ? {28'h0, istat_q} :
                                     hit_imk  ? {28'h0, imask_q} :
                                     hit_cnt  ? count_q : 32'h0;
    wire [SPS_EV_W-1:0]   ist_clr  = (apb_wr && hit_ist) ? pwdata_in[SPS_EV_W-1:0] : '0;
    wire [SPS_EV_W-1:0]   ist_d    = (istat_q & ~ist_clr) | ev_set;

    assign ev_set[SPS_EV_DONE]    = commit;
    assign ev_set[SPS_EV_ILLEGAL] = refuse;
    assign ev_set[SPS_EV_FAULT]   = fault;
    assign ev_set[SPS_EV_ABORT]   = abort;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:   if (accept) state_d = ST_ACCESS;
            ST_ACCESS: if (commit || fault || abort) state_d = ST_IDLE;
        endcase
    end

    // apb slave and interrupt registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0;
            pslverr_out <= 1'b0;
            ctrl_q      <= SPS_CTRL_RST;
            imask_q     <= '0;
            istat_q     <= '0;
            irq_out     <= 1'b0;
            count_q     <= 32'h0;
        end
        else
        begin
            pready_out  <= apb_acc;
            prdata_out  <= (apb_acc && !pwrite_in) ? rd_mux : 32'h0;
            pslverr_out <= apb_acc && !hit_any;
            if (apb_wr && hit_ctrl)
                ctrl_q <= pwdata_in[1:0];
            if (apb_wr && hit_imk)
                imask_q <= pwdata_in[SPS_EV_W-1:0];
            istat_q     <= ist_d;
            irq_out     <= |(ist_d & imask_q);
            count_q     <= count_q + 32'(commit);
        end
    end

    // access sequencer
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q       <= ST_IDLE;
            idx_q         <= 4'h0;
            bytes_q       <= SPS_BYTES_W;
            adj_q         <= 8'h0;
            push_q        <= 1'b0;
            sp_q          <= '0;
            pc_q          <= '0;
            mem_req_out   <= 1'b0;
            mem_write_out <= 1'b0;
            mem_dword_out <= 1'b0;
            mem_addr_out  <= '0;
            mem_reg_out   <= 5'h0;
        end
        else
        begin
            state_q <= state_d;
            if (accept)
            begin
                idx_q         <= dec_first;
                bytes_q       <= dec_bytes;
                adj_q         <= dec_adj;
                push_q        <= is_push_in;
                sp_q          <= sp_in;
                pc_q          <= pc_in;
                mem_req_out   <= 1'b1;
                mem_write_out <= is_push_in;
                mem_dword_out <= dec_bytes == SPS_BYTES_D;
                mem_addr_out  <= first_a;
                mem_reg_out   <= sps_reg_num(dec_first);
            end
            else if (ack_ok && !last)
            begin
                idx_q        <= idx_q + 4'h1;
                mem_addr_out <= step_a;
                mem_reg_out  <= sps_reg_num(idx_q + 4'h1);
            end
            else if (commit || fault || abort)
                mem_req_out <= 1'b0;
        end
    end

    // commit and trap reporting
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            busy_out       <= 1'b0;
            done_out       <= 1'b0;
            sp_we_out      <= 1'b0;
            sp_new_out     <= '0;
            trap_out       <= 1'b0;
            trap_cause_out <= SPS_CAUSE_NONE;
            trap_epc_out   <= '0;
            trap_tval_out  <= '0;
        end
        else
        begin
            busy_out  <= state_d == ST_ACCESS;
            done_out  <= commit;
            sp_we_out <= commit;
            if (commit)
                sp_new_out <= sp_fin;
            trap_out  <= refuse || fault || abort;
            if (refuse)
            begin
                trap_cause_out <= SPS_CAUSE_ILLEGAL;
                trap_epc_out   <= pc_in;
                trap_tval_out  <= '0;
            end
            else if (fault || abort)
            begin
                trap_cause_out <= fault ? SPS_CAUSE_ACCESS : SPS_CAUSE_INTR;
                trap_epc_out   <= pc_q;
                trap_tval_out  <= fault ? mem_addr_out : '0;
            end
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_last_ok;
        mem_req_out && mem_ack_in && !mem_err_in && idx_q == SPS_LAST_IDX;
    endsequence

    a_reserved_refused: assert property (idle && start_in && rlist_in < SPS_RLIST_MIN
        |=> trap_out && trap_cause_out == SPS_CAUSE_ILLEGAL && !mem_req_out)
        else $error("reserved code not refused");
    a_full_list: assert property (rlist_in == SPS_RLIST_FULL |-> &dec_sel)
        else $error("code 15 does not select all registers");
    a_x26_with_x27: assert property (dec_sel[SPS_SLOT_X26] |-> dec_sel[SPS_SLOT_X27])
        else $error("x26 selected without x27");
    a_frame_sum: assert property (accept |=> adj_q == $past(dec_base) + 8'h10 * 8'($past(spimm_in[5:4])))
        else $error("frame adjustment wrong");
    a_embedded_base: assert property (ctrl_q == SPS_EMB32 |-> dec_base == 8'h10)
        else $error("embedded base not sixteen");
    a_rv32_top_base: assert property (ctrl_q == SPS_RV32 && rlist_in == SPS_RLIST_FULL |-> dec_base == 8'h40)
        else $error("32-bit base for full list wrong");
    a_rv64_top_base: assert property (ctrl_q == SPS_RV64 && rlist_in == SPS_RLIST_FULL |-> dec_base == 8'h70)
        else $error("64-bit base for full list wrong");
    a_access_size: assert property (mem_req_out |-> mem_dword_out == (bytes_q == SPS_BYTES_D))
        else $error("access size mismatch");
    a_push_first: assert property (accept && is_push_in |=> mem_addr_out == $past(sp_in) - 64'($past(dec_bytes)))
        else $error("push start address wrong");
    a_pop_first: assert property (accept && !is_push_in
        |=> mem_addr_out == $past(sp_in) + 64'($past(dec_adj)) - 64'($past(dec_bytes)))
        else $error("pop start address wrong");
    a_step_down: assert property (ack_ok && !last
        |=> mem_addr_out == $past(mem_addr_out) - 64'(bytes_q) && idx_q == $past(idx_q) + 4'h1)
        else $error("address did not step down");
    a_commit_after: assert property (s_last_ok |=> sp_we_out && sp_new_out == $past(sp_fin) ##1 !sp_we_out)
        else $error("sp not committed once after last access");
    a_no_early_sp: assert property (sp_we_out |-> $past(commit))
        else $error("sp written without completed accesses");
    a_fault_no_commit: assert property ((fault || abort) |=> trap_out && !sp_we_out ##1 !sp_we_out)
        else $error("sp committed after fault or interrupt");
    a_fault_report: assert property (fault |=> trap_cause_out == SPS_CAUSE_ACCESS
        && trap_epc_out == pc_q && trap_tval_out == $past(mem_addr_out))
        else $error("fault report wrong");
    a_restart_clean: assert property (abort |=> !mem_req_out && idle)
        else $error("sequence not abandoned for restart");
    a_illegal_refused: assert property (refuse
        |=> trap_out && trap_cause_out == SPS_CAUSE_ILLEGAL && !mem_req_out && idle)
        else $error("illegal frame not refused");

endmodule : sps_sequencer

// >>> testbench/sps_mem_model.sv
`timescale 1ns/1ps
module sps_mem_model
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // request from the sequencer
    input  wire logic        req_in,
    input  wire logic [63:0] addr_in,
    // behaviour chosen by the bench
    input  wire logic [3:0]  wait_in,
    input  wire logic        err_en_in,
    input  wire logic [63:0] err_addr_in,
    // answer
    output logic             ack_out,
    output logic             err_out
);
    logic [3:0] cnt_q;

    // ack after wait_in idle cycles, one pulse per access, error only on the chosen address
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q   <= 4'h0;
            ack_out <= 1'b0;
            err_out <= 1'b0;
        end
        else if (!req_in || ack_out)
        begin
            cnt_q   <= 4'h0;
            ack_out <= 1'b0;
            err_out <= 1'b0;
        end
        else if (cnt_q >= wait_in)
        begin
            ack_out <= 1'b1;
            err_out <= err_en_in && (addr_in == err_addr_in);
        end
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule : sps_mem_model

// >>> testbench/sps_sequencer_tb_top.sv
`timescale 1ns/1ps
module sps_sequencer_tb_top;
    import sps_pkg::*;
    logic        ref_clk_in = 1'b0, rst_n_in = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic        start_in = 1'b0, is_push_in = 1'b0, intr_in = 1'b0, mem_ack_in, mem_err_in;
    logic [3:0]  rlist_in = 4'h0, mwait = 4'h0;
    logic [5:0]  spimm_in = 6'h00;
    logic [63:0] sp_in = 64'h0, pc_in = 64'h0, merr_addr = 64'h0;
    logic        merr_en = 1'b0, mem_req_out, mem_write_out, mem_dword_out;
    logic [63:0] mem_addr_out, sp_new_out, trap_epc_out, trap_tval_out;
    logic [4:0]  mem_reg_out;
    logic        busy_out, done_out, sp_we_out, trap_out, irq_out;
    sps_cause_t  trap_cause_out;
    logic [70:0] acc_q[$];
    int          fails = 0, check_count = 0, we_cnt = 0, we_at = 0, commits = 0;
    int          seq_tab[13] = '{27, 26, 25, 24, 23, 22, 21, 20, 19, 18, 9, 8, 1};

    always #5 ref_clk_in = ~ref_clk_in;

    sps_sequencer uut (.ref_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pready_out, .prdata_out, .pslverr_out, .start_in, .is_push_in, .rlist_in, .spimm_in, .sp_in, .pc_in,
        .intr_in, .mem_req_out, .mem_write_out, .mem_dword_out, .mem_addr_out, .mem_reg_out, .mem_ack_in,
        .mem_err_in, .busy_out, .done_out, .sp_we_out, .sp_new_out, .trap_out, .trap_cause_out, .trap_epc_out,
        .trap_tval_out, .irq_out);

    sps_mem_model mem (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_in(mem_req_out), .addr_in(mem_addr_out),
        .wait_in(mwait), .err_en_in(merr_en), .err_addr_in(merr_addr), .ack_out(mem_ack_in), .err_out(mem_err_in));

    // record every finished access and the moment of the sp write
    always @(posedge ref_clk_in)
    begin
        if (mem_req_out && mem_ack_in)
            acc_q.push_back({mem_write_out, mem_dword_out, mem_reg_out, mem_addr_out});
        if (sp_we_out)
        begin
            we_cnt++;
            we_at = acc_q.size();
        end
    end

    task automatic chk(input logic [70:0] got, input logic [70:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [32:0] rd);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        // only the watchdog ends a wait for the answer
        do
            @(posedge ref_clk_in);
        while (pready_out !== 1'b1);
        rd = {pslverr_out, prdata_out};
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] rd;
        apb(1'b1, a, d, rd);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [32:0] exp);
        logic [32:0] rd;
        apb(1'b0, a, 32'h0, rd);
        chk(rd, exp, "apb read");
    endtask : rdchk

    function automatic int base_of(input logic [1:0] v, input logic [3:0] c);
        if (v == 2'h0)
            return 16;
        if (v == 2'h1)
            return c == 4'hf ? 64 : c > 4'hb ? 48 : c > 4'h7 ? 32 : 16;
        return c == 4'hf ? 112 : c == 4'he ? 96 : 16 * ((c - 2) / 2);
    endfunction : base_of

    task automatic run(input logic push, input logic [1:0] v, input logic [3:0] c, input logic [5:0] imm,
                       input int err_i, input int intr_at);
        logic [63:0] sp, a, pc;
        int          bytes, n, adj, k;
        logic        got_done, got_trap, got_busy;
        sps_cause_t  cause;
        sp = 64'h8000_1000 + {60'h0, c} * 64'h100;
        pc = sp ^ 64'h0000_4000_0000_0002;
        bytes = v == 2'h2 ? 8 : 4;
        n = c == 4'hf ? 13 : int'(c) - 3;
        adj = base_of(v, c) + int'(imm[5:4]) * 16;
        a = push ? sp - bytes : sp + adj - bytes;
        cause = (c < 4'h4 || v == 2'h3 || (v == 2'h0 && c > 4'h7)) ? SPS_CAUSE_ILLEGAL :
                err_i >= 0 ? SPS_CAUSE_ACCESS : intr_at >= 0 ? SPS_CAUSE_INTR : SPS_CAUSE_NONE;
        merr_addr <= a - err_i * bytes;
        merr_en <= err_i >= 0;
        acc_q.delete();
        we_cnt = 0;
        start_in <= 1'b1;
        is_push_in <= push;
        rlist_in <= c;
        spimm_in <= imm;
        sp_in <= sp;
        pc_in <= pc;
        @(posedge ref_clk_in);
        start_in <= 1'b0;
        got_done = 1'b0;
        got_trap = 1'b0;
        for (k = 0; k < 200 && !got_done && !got_trap; k++)
        begin
            @(posedge ref_clk_in);
            if (k == 0)
                got_busy = busy_out;
            if (k == intr_at)
                intr_in <= 1'b1;
            got_done = done_out;
            got_trap = trap_out;
        end
        intr_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        chk({got_busy, busy_out}, {cause != SPS_CAUSE_ILLEGAL, 1'b0}, "busy");
        if (cause != SPS_CAUSE_NONE)
        begin
            chk({got_trap, trap_cause_out, trap_epc_out}, {1'b1, cause, pc}, "trap");
            chk(we_cnt, 0, "sp write after trap");
            if (cause == SPS_CAUSE_ILLEGAL)
                chk(acc_q.size(), 0, "accesses of illegal code");
            if (cause == SPS_CAUSE_ACCESS)
                chk({7'(acc_q.size()), trap_tval_out}, {7'(err_i + 1), a - err_i * bytes}, "fault");
            else
                chk(trap_tval_out, 64'h0, "no fault address");
        end
        else
        begin
            chk(acc_q.size(), n, "access count");
            for (k = 0; k < n && k < acc_q.size(); k++)
                chk(acc_q[k], {push, bytes == 8, 5'(seq_tab[13 - n + k]), a - k * bytes}, "access");
            chk({got_done, sp_new_out}, {1'b1, push ? sp - adj : sp + adj}, "new sp");
            chk({we_cnt, we_at}, {32'h1, n}, "sp write once after accesses");
            commits++;
        end
    endtask : run

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (30000) @(posedge ref_clk_in);
        fails++;
        final_report();
    end

    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        rdchk(SPS_ADDR_CTRL, 33'h1);
        rdchk(SPS_ADDR_STATUS, 33'h0);
        rdchk(SPS_ADDR_ISTAT, 33'h0);
        rdchk(SPS_ADDR_IMASK, 33'h0);
        rdchk(SPS_ADDR_COUNT, 33'h0);
        rdchk(8'h20, 33'h1_0000_0000);
        for (int v = 0; v < 4; v++)
        begin
            wr(SPS_ADDR_CTRL, 32'(v));
            rdchk(SPS_ADDR_CTRL, 33'(v));
            for (int c = 0; c < 16; c++)
            begin
                mwait <= 4'(c % 3);
                run(c[0], 2'(v), 4'(c), {2'(c + v), 4'h0}, -1, -1);
            end
        end
        wr(SPS_ADDR_CTRL, 32'h2);
        mwait <= 4'h1;
        run(1'b1, 2'h2, 4'hf, 6'h30, 4, -1);
        run(1'b1, 2'h2, 4'hf, 6'h30, -1, -1);
        mwait <= 4'h5;
        run(1'b0, 2'h2, 4'h9, 6'h10, -1, 3);
        rdchk(SPS_ADDR_ISTAT, 33'hf);
        chk(irq_out, 1'b0, "irq masked");
        wr(SPS_ADDR_IMASK, 32'h4);
        @(posedge ref_clk_in);
        chk(irq_out, 1'b1, "irq raised");
        wr(SPS_ADDR_ISTAT, 32'h4);
        @(posedge ref_clk_in);
        chk(irq_out, 1'b0, "irq cleared");
        rdchk(SPS_ADDR_ISTAT, 33'hb);
        wr(SPS_ADDR_STATUS, 32'hff);
        // idle, slot index still at the first slot of the aborted code 9 sequence
        rdchk(SPS_ADDR_STATUS, 33'h0e);
        rdchk(SPS_ADDR_COUNT, 33'(commits));
        final_report();
    end
endmodule : sps_sequencer_tb_top
